// ### verif/trr_host_model.sv
// Host partner: writes commands and reads reply bytes over the link
`timescale 1ns/1ps
module trr_host_model (
   input  wire logic             host_clk_in,
   input  wire logic [7:0]       host_tx_byte_in,
   output trr_pkg::trr_host_rx_s host_rx_out,
   output logic                  host_tx_req_out,
   output logic                  link_en_out
);
   import trr_pkg::*;
   initial begin
      host_rx_out = '0;
      host_tx_req_out = 1'b0;
      link_en_out = 1'b1;
   end
   // Two idle link cycles follow each byte so the core sees command and event apart
   task automatic put(input logic first, input logic [7:0] d);
      link_en_out = 1'b1;
      @(posedge host_clk_in) #1 host_rx_out = '{valid: 1'b1, first: first, data: d};
      @(posedge host_clk_in) #1 host_rx_out = '{valid: 1'b0, first: 1'b0, data: ~d};
      @(posedge host_clk_in);
   endtask
   task automatic get(output logic [7:0] d);
      link_en_out = 1'b1;
      @(posedge host_clk_in) #1 host_tx_req_out = 1'b1;
      @(posedge host_clk_in) #1 host_tx_req_out = 1'b0;
      @(posedge host_clk_in) #1 d = host_tx_byte_in;
   endtask
   // Serial clock stands still between transactions
   task automatic idle();
      @(posedge host_clk_in) link_en_out = 1'b0;
   endtask
   task automatic fetch(output logic [7:0] r [4]);
      put(1'b1, CMD_FETCH);
      for (int i = 0; i < 4; i++) get(r[i]);
      idle();
   endtask
   task automatic answer(input logic ok, input logic [7:0] d [$], output logic [7:0] st);
      put(1'b1, ok ? ANS_NORMAL : ANS_ERROR);
      if (ok) foreach (d[i]) put(1'b0, d[i]);
      get(st);
      idle();
   endtask
endmodule // trr_host_model

// ### verif/trr_read_relay_bench.sv
// Self-checking bench of the tunnel-mode read relay
`timescale 1ns/1ps
module trr_read_relay_bench;
   import trr_pkg::*;
   localparam int FW = 200;
   localparam int AW = 400;
   logic         clk_in = 1'b0;
   logic         rst_n_in = 1'b0;
   logic         host_clk = 1'b0;
   logic         link_en;
   trr_rf_rx_s   rf_rx = '0;
   logic         rf_ready = 1'b0;
   trr_rf_tx_s   rf_tx;
   trr_rf_tx_s   b;
   logic         irq_n;
   trr_host_rx_s host_rx;
   logic         host_req;
   logic [7:0]   host_byte;
   logic [7:0]   r [4];
   logic [7:0]   st;
   logic [7:0]   none [$];
   int           waited;
   int           fail_count = 0;
   int           tests_run = 0;
   always #5 clk_in = ~clk_in;
   initial begin
      #7;
      forever #15 host_clk = link_en ? ~host_clk : 1'b0;
   end
   trr_read_relay #(.FETCH_WAIT_CYC(FW), .ANS_WAIT_CYC(AW)) u_dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .host_clk_in(host_clk), .rf_rx_in(rf_rx),
      .rf_tx_ready_in(rf_ready), .rf_tx_out(rf_tx), .host_irq_n_out(irq_n),
      .host_rx_in(host_rx), .host_tx_req_in(host_req), .host_tx_byte_out(host_byte));
   trr_host_model u_host (.host_clk_in(host_clk), .host_tx_byte_in(host_byte),
      .host_rx_out(host_rx), .host_tx_req_out(host_req), .link_en_out(link_en));
   // ----------------
   // Helpers
   // ----------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic done(input string s);
      $display("%s finished, %0d mismatches so far", s, fail_count);
   endtask
   // Block-list frames get an 8-byte card id inserted after the code
   task automatic send(input logic apdu, input logic [7:0] f [$]);
      for (int k = 0; k < 8 && !apdu; k++) f.insert(1, 8'h20 + 8'(k));
      foreach (f[i]) begin
         @(posedge clk_in) #1 rf_rx = '{valid: 1'b1, last: i == f.size() - 1, apdu: apdu, data: f[i]};
      end
      @(posedge clk_in) #1 rf_rx = '{valid: 1'b0, last: 1'b0, apdu: apdu, data: ~f[f.size() - 1]};
   endtask
   task automatic beat(input int lim);
      for (waited = 0; waited < lim; waited++) begin
         @(posedge clk_in) #1;
         if (rf_tx.valid === 1'b1) begin
            b = rf_tx;
            rf_ready = 1'b1;
            @(posedge clk_in) #1 rf_ready = 1'b0;
            return;
         end
      end
      chk(8'h00, 8'h01, "no response beat");
      stop_test();
   endtask
   task automatic wait_irq(input logic lvl, input int lim);
      for (int n = 0; n < lim; n++) begin
         @(posedge clk_in) #1;
         if (irq_n === lvl) return;
      end
      chk({7'h0, irq_n}, {7'h0, lvl}, "irq level");
      stop_test();
   endtask
   task automatic err_beat(input int lim);
      beat(lim);
      chk({6'h0, b.err, b.last}, 8'h03, "error beat");
      chk(b.data, 8'h00, "error data");
      chk({7'h0, irq_n}, 8'h01, "irq high");
   endtask
   task automatic read_apdu();
      send(1'b1, '{APDU_CLASS, RD_INS_APDU, 8'h1a, 8'h7e, 8'h03});
      wait_irq(1'b0, 8);
   endtask
   task automatic bad(input logic apdu, input logic [7:0] f [$]);
      send(apdu, f);
      err_beat(10);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_apdu();
      logic [7:0] d [$] = '{8'h3c, 8'ha5, 8'h0f};
      u_host.fetch(r);
      chk(r[0], STAT_ERR, "idle fetch");
      read_apdu();
      repeat (30) @(posedge clk_in);
      chk({7'h0, irq_n}, 8'h00, "irq stands");
      u_host.fetch(r);
      chk(r[0], STAT_OK, "fetch status");
      chk(r[1], 8'h4a, "addr hi");
      chk(r[2], 8'h7e, "addr lo");
      chk(r[3], 8'h03, "length");
      wait_irq(1'b1, 10);
      u_host.answer(1'b1, d, st);
      chk(st, STAT_OK, "answer status");
      repeat (30) @(posedge clk_in);
      #1 chk({rf_tx.valid, rf_tx.data[6:0]}, {1'b1, d[0][6:0]}, "stalled beat");
      foreach (d[i]) begin
         beat(20);
         chk(b.data, d[i], "data beat");
         chk({6'h0, b.err, b.last}, {7'h0, i == 2}, "beat flags");
      end
      done("apdu read");
   endtask
   task automatic t_block();
      send(1'b0, '{RD_CODE_BL, 8'h02, 8'h09, 8'h00, 8'h09, 8'h00, 8'h01, 8'h80, 8'h35});
      wait_irq(1'b0, 8);
      u_host.fetch(r);
      chk(r[1], 8'h43, "addr hi");
      chk(r[2], 8'h50, "addr lo");
      chk(r[3], 8'h10, "length");
      u_host.answer(1'b0, none, st);
      chk(st, STAT_OK, "answer status");
      err_beat(40);
      done("block read");
   endtask
   task automatic t_bad();
      bad(1'b1, '{8'h01, RD_INS_APDU, 8'h00, 8'h00, 8'h03});
      bad(1'b1, '{APDU_CLASS, RD_INS_APDU, 8'h00, 8'h00, 8'h00});
      bad(1'b1, '{APDU_CLASS, RD_INS_APDU, 8'h00, 8'h00, 8'hfc});
      bad(1'b1, '{APDU_CLASS, RD_INS_APDU, 8'h00, 8'h00, 8'h03, 8'h00});
      bad(1'b1, '{APDU_CLASS, WR_INS_APDU, 8'h00, 8'h00, 8'h03});
      bad(1'b0, '{RD_CODE_BL, 8'h00, 8'h01, 8'h80, 8'h00});
      bad(1'b0, '{RD_CODE_BL, 8'h02, 8'h09, 8'h00, 8'h09, 8'h01, 8'h01, 8'h80, 8'h00});
      bad(1'b0, '{RD_CODE_BL, 8'h01, 8'h09, 8'h00, 8'h00});
      bad(1'b0, '{WR_CODE_BL, 8'h01, 8'h09, 8'h00, 8'h01, 8'h80, 8'h00});
      done("bad frames");
   endtask
   task automatic t_timeouts();
      read_apdu();
      err_beat(FW + 20);
      chk({7'h0, waited >= FW - 6}, 8'h01, "fetch wait length");
      read_apdu();
      u_host.fetch(r);
      chk(r[0], STAT_OK, "fetch status");
      err_beat(AW + 40);
      chk({7'h0, waited >= AW - 60}, 8'h01, "answer wait length");
      done("timeouts");
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      repeat (10) @(posedge clk_in);
      t_apdu();
      t_block();
      t_bad();
      t_timeouts();
      stop_test();
   end
endmodule // trr_read_relay_bench

// ### verif/trr_read_relay_chk.sv
// Port-level concurrent checks of the tunnel-mode read relay
`timescale 1ns/1ps
module trr_read_relay_chk #(
   parameter int unsigned FETCH_WAIT_CYC = 200,
   parameter int unsigned ANS_WAIT_CYC   = 400
) (
   input wire logic                  clk_in,
   input wire logic                  rst_n_in,
   input wire logic                  host_clk_in,
   input wire trr_pkg::trr_rf_rx_s   rf_rx_in,
   input wire logic                  rf_tx_ready_in,
   input wire trr_pkg::trr_rf_tx_s   rf_tx_out,
   input wire logic                  host_irq_n_out,
   input wire trr_pkg::trr_host_rx_s host_rx_in,
   input wire logic                  host_tx_req_in,
   input wire logic [7:0]            host_tx_byte_out
);
   import trr_pkg::*;
   logic [15:0] low_cnt_q;
   logic [2:0]  rd_idx_q;
   logic [7:0]  cmd_q;
   logic        ok_q;
   wire         cmd_start = host_rx_in.valid && host_rx_in.first;
   // A reply byte is judged just before the next read or command replaces it
   wire         reply_seen = host_tx_req_in || cmd_start;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) low_cnt_q <= '0;
      else low_cnt_q <= host_irq_n_out ? 16'h0000 : low_cnt_q + 16'h0001;
   end
   always_ff @(posedge host_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_idx_q <= '0;
         cmd_q    <= '0;
         ok_q     <= 1'b0;
      end else begin
         if (reply_seen && rd_idx_q == 3'h1) ok_q <= (host_tx_byte_out == STAT_OK);
         if (cmd_start) rd_idx_q <= '0;
         else if (host_tx_req_in && rd_idx_q != 3'h7) rd_idx_q <= rd_idx_q + 3'h1;
         if (cmd_start) cmd_q <= host_rx_in.data;
      end
   end
   // ----------------
   // Sequences
   // ----------------
   sequence s_err_beat;
      rf_tx_out.valid && rf_tx_out.err;
   endsequence
   sequence s_reply(int k);
      reply_seen && rd_idx_q == 3'(k);
   endsequence
   // ----------------
   // Assertions
   // ----------------
   a_irq_fall_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(host_irq_n_out) |-> $past(rf_rx_in.valid && rf_rx_in.last, 2))
      else $error("interrupt fell without a frame end");
   a_irq_quiet_tx: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !host_irq_n_out |-> !rf_tx_out.valid) else $error("response beat while interrupt low");
   a_fetch_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      32'(low_cnt_q) <= FETCH_WAIT_CYC + 4) else $error("interrupt held past fetch wait");
   a_err_shape: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_err_beat |-> rf_tx_out.last && rf_tx_out.data == 8'h00) else $error("bad error beat");
   a_beat_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rf_tx_out.valid && !rf_tx_ready_in |=> rf_tx_out.valid && $stable(rf_tx_out))
      else $error("beat changed before ready");
   a_tx_stands: assert property (@(posedge host_clk_in) disable iff (!rst_n_in)
      !$past(host_tx_req_in) |-> $stable(host_tx_byte_out))
      else $error("reply byte changed without a read");
   a_status_first: assert property (@(posedge host_clk_in) disable iff (!rst_n_in)
      s_reply(1) |-> host_tx_byte_out == STAT_OK || host_tx_byte_out == STAT_ERR)
      else $error("first reply byte is not a status");
   a_addr_marker: assert property (@(posedge host_clk_in) disable iff (!rst_n_in)
      s_reply(2) ##0 (cmd_q == CMD_FETCH && ok_q) |-> host_tx_byte_out[7:4] == 4'b0100)
      else $error("address top bits wrong");
endmodule // trr_read_relay_chk

bind trr_read_relay trr_read_relay_chk #(.FETCH_WAIT_CYC(FETCH_WAIT_CYC), .ANS_WAIT_CYC(ANS_WAIT_CYC)) u_chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .host_clk_in(host_clk_in), .rf_rx_in(rf_rx_in),
   .rf_tx_ready_in(rf_tx_ready_in), .rf_tx_out(rf_tx_out), .host_irq_n_out(host_irq_n_out),
   .host_rx_in(host_rx_in), .host_tx_req_in(host_tx_req_in), .host_tx_byte_out(host_tx_byte_out));

// ### verilog/trr_pkg.sv
// Constants, carriers and helpers of the tunnel-mode read relay
package trr_pkg;

   // ----------------
   // Command codes
   // ----------------
   localparam logic [7:0] RD_CODE_BL  = 8'h06;
   localparam logic [7:0] RD_INS_APDU = 8'hb0;
   localparam logic [7:0] WR_CODE_BL  = 8'h08;
   localparam logic [7:0] WR_INS_APDU = 8'hd6;
   localparam logic [7:0] CMD_FETCH   = 8'h28;
   localparam logic [7:0] ANS_NORMAL  = 8'hf8;
   localparam logic [7:0] ANS_ERROR   = 8'he8;
   localparam logic [7:0] APDU_CLASS  = 8'h00;

   // ----------------
   // Field limits and positions
   // ----------------
   localparam logic [7:0] CNT_MIN     = 8'h01;
   localparam logic [7:0] CNT_MAX     = 8'h0f;
   localparam logic [7:0] LE_MAX      = 8'hfb;
   localparam logic [7:0] POS_CODE    = 8'h00;
   localparam logic [7:0] POS_INS     = 8'h01;
   localparam logic [7:0] POS_P1      = 8'h02;
   localparam logic [7:0] POS_P2      = 8'h03;
   localparam logic [7:0] POS_LE      = 8'h04;
   localparam logic [7:0] POS_SVC_CNT = 8'h09;
   localparam logic [7:0] POS_SVC     = 8'h0a;
   localparam logic [1:0] ADDR_TOP    = 2'b01;
   localparam logic [1:0] MODE_READ   = 2'b00;
   localparam int         BUF_DEPTH   = 251;

   // ----------------
   // Status bytes to the host (values arbitrary)
   // ----------------
   localparam logic [7:0] STAT_OK     = 8'h00;
   localparam logic [7:0] STAT_ERR    = 8'hff;

   // ----------------
   // Timing
   // ----------------
   localparam int unsigned CLK_FREQ_MHZ         = 100;
   localparam int unsigned HOST_FETCH_REQUEST_CMD_WAIT_TIME_US   = 100;
   localparam int unsigned ANSWER_WAIT_TIME_US  = 1000;
   localparam int unsigned FETCH_WAIT_CYCLES    = HOST_FETCH_REQUEST_CMD_WAIT_TIME_US * CLK_FREQ_MHZ;
   localparam int unsigned ANSWER_WAIT_CYCLES   = ANSWER_WAIT_TIME_US * CLK_FREQ_MHZ;

   // ----------------
   // Types
   // ----------------
   typedef enum logic [2:0] {S_IDLE, S_CHECK, S_FETCH, S_ANSWER, S_SEND, S_ERROR} trr_state_e;
   typedef struct packed {logic valid; logic last; logic apdu; logic [7:0] data;} trr_rf_rx_s;
   typedef struct packed {logic valid; logic last; logic err; logic [7:0] data;} trr_rf_tx_s;
   typedef struct packed {logic valid; logic first; logic [7:0] data;} trr_host_rx_s;
   typedef struct packed {logic [15:0] addr; logic [7:0] len;} trr_fetch_s;

   function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

endpackage

// ### verilog/trr_read_relay.sv
// Tunnel-mode read relay: RF read parser, host fetch/answer server, data return
// Operation
// RL1: Reader read uses code 0x06 block-list, instruction 0xb0 APDU.
// RL2: Reader write uses code 0x08 / 0xd6; relaying it is not done here.
// RL3: Host fetch-request is command byte 0x28.
// RL4: Host result-reply starts with 0xf8 normal or 0xe8 error.
// RL5: Error result-reply carries only the command byte.
// RL6: Block-list frame: code, 8-byte id, k, 2k ids, m, block list.
// RL7: Service count outside 1..15 gives an error response.
// RL8: Service ids ignored but must all be identical.
// RL9: Block count outside 1..15 gives an error response.
// RL10: APDU class byte other than 0x00 gives an error.
// RL11: P1/P2 give start address; Le must be 1..251.
// RL12: APDU read is exactly class, instruction, P1, P2, Le.
// RL13: Fetch reply: status byte, then 2-byte address, high byte first.
// RL14: Fetch reply ends with the byte count the host must supply.
// RL15: Normal result-reply carries exactly the announced data bytes.
// RL16: Every result-reply is acknowledged by one status byte.
// RL17: Fetch-request is exactly one byte.
// RL18: Interrupt goes low when a valid tunnel read arrives.
// RL19: No fetch within host_fetch_request_cmd wait time after interrupt gives timeout.
// RL20: Answer wait starts after first normal fetch reply; expiry errors.
// RL21: Address upper byte bit 7 forced 0, bit 6 forced 1, bits 5:4 mode.
// RL22: After the status byte, normal answer data goes to the reader.
`timescale 1ns/1ps
module trr_read_relay #(
   parameter int unsigned FETCH_WAIT_CYC = trr_pkg::FETCH_WAIT_CYCLES,
   parameter int unsigned ANS_WAIT_CYC   = trr_pkg::ANSWER_WAIT_CYCLES
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  host_clk_in,
   input  wire trr_pkg::trr_rf_rx_s   rf_rx_in,
   input  wire logic                  rf_tx_ready_in,
   output trr_pkg::trr_rf_tx_s        rf_tx_out,
   output logic                       host_irq_n_out,
   input  wire trr_pkg::trr_host_rx_s host_rx_in,
   input  wire logic                  host_tx_req_in,
   output logic [7:0]                 host_tx_byte_out
);
   import trr_pkg::*;

   // ----------------------------------------------------------------
   // Core domain state
   // ----------------------------------------------------------------
   trr_state_e  state_q;
   logic [7:0]  pos_q;
   logic        err_q;
   logic        ok_q;
   logic        apdu_q;
   logic [7:0]  a1_q;
   logic [7:0]  a2_q;
   logic [7:0]  ln_q;
   logic [7:0]  k_q;
   logic [15:0] svc_q;
   logic [1:0]  eb_q;
   logic        e3_q;
   logic [7:0]  elem_q;
   trr_fetch_s  fetch_q;
   logic        pend_q;
   logic        irq_n_q;
   logic [31:0] tmr_q;
   logic [7:0]  idx_q;
   trr_rf_tx_s  tx_q;
   logic [2:0]  f_sy_q;
   logic [2:0]  ok_sy_q;
   logic [2:0]  er_sy_q;

   // Link domain state
   logic [7:0]  ans_buf [BUF_DEPTH];
   logic [1:0]  pend_sy_q;
   logic [7:0]  cmd_q;
   logic [7:0]  rxn_q;
   logic [1:0]  txi_q;
   logic        qseen_q;
   logic        adone_q;
   logic        f_tgl_q;
   logic        ok_tgl_q;
   logic        er_tgl_q;
   logic [7:0]  htx_q;

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   wire logic       take    = (state_q == S_IDLE) && rf_rx_in.valid;
   wire logic [7:0] b       = rf_rx_in.data;
   wire logic       ap      = rf_rx_in.apdu;
   wire logic [7:0] mpos    = POS_SVC + {k_q[6:0], 1'b0};
   wire logic       past_k  = pos_q > POS_SVC_CNT;
   wire logic       svc_win = !ap && (pos_q >= POS_SVC) && (pos_q < mpos);
   wire logic [7:0] svc_off = pos_q - POS_SVC;
   wire logic [7:0] svc_ref = svc_off[0] ? svc_q[7:0] : svc_q[15:8];
   wire logic       el_b    = !ap && past_k && (pos_q > mpos);
   wire logic       e_end   = (eb_q == 2'd1 && !e3_q) || (eb_q == 2'd2);
   wire logic [7:0] elem_nx = elem_q + {7'd0, el_b && e_end};

   // A write code lands here as an error; the write relay is not built
   wire logic bad_ap = (pos_q == POS_CODE && b != APDU_CLASS)                  // RL10
                     || (pos_q == POS_INS && b != RD_INS_APDU)                 // RL1 RL2
                     || (pos_q == POS_LE && !in_rng(b, CNT_MIN, LE_MAX))       // RL11
                     || (pos_q > POS_LE);                                      // RL12
   wire logic bad_bl = (pos_q == POS_CODE && b != RD_CODE_BL)                  // RL1 RL2
                     || (pos_q == POS_SVC_CNT && !in_rng(b, CNT_MIN, CNT_MAX)) // RL7
                     || (svc_win && svc_off > 8'd1 && b != svc_ref)            // RL8
                     || (past_k && pos_q == mpos && !in_rng(b, CNT_MIN, CNT_MAX)); // RL9
   wire logic bad    = ap ? bad_ap : bad_bl;
   wire logic end_ok = ap ? (pos_q == POS_LE)                                  // RL12
                        : (el_b && e_end && elem_nx == ln_q);                  // RL6

   // Tunnel marker and mode forced into the upper address bits
   wire logic [15:0] addr_w = apdu_q ? {ADDR_TOP, MODE_READ, a1_q[3:0], a2_q}   // RL11 RL21
                                     : {ADDR_TOP, MODE_READ, a2_q, 4'h0};       // RL21
   wire logic [7:0]  len_w  = apdu_q ? ln_q : {ln_q[3:0], 4'h0};

   // ----------------------------------------------------------------
   // Frame capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pos_q  <= 8'h00;
         err_q  <= 1'b0;
         ok_q   <= 1'b0;
         apdu_q <= 1'b0;
         a1_q   <= 8'h00;
         a2_q   <= 8'h00;
         ln_q   <= 8'h00;
         k_q    <= 8'h00;
         svc_q  <= 16'h0000;
         eb_q   <= 2'd0;
         e3_q   <= 1'b0;
         elem_q <= 8'h00;
      end else if (take) begin
         pos_q  <= rf_rx_in.last ? 8'h00 : pos_q + 8'h01;
         err_q  <= rf_rx_in.last ? 1'b0 : (err_q | bad);
         ok_q   <= !err_q && !bad && end_ok;
         apdu_q <= ap;
         if (ap && pos_q == POS_P1) a1_q <= b;
         if (ap && pos_q == POS_P2) a2_q <= b;
         if (ap && pos_q == POS_LE) ln_q <= b;
         if (!ap && pos_q == POS_SVC_CNT) k_q <= b;
         if (svc_win && svc_off == 8'd0) svc_q[15:8] <= b;
         if (svc_win && svc_off == 8'd1) svc_q[7:0] <= b;
         if (!ap && past_k && pos_q == mpos) ln_q <= b;
         // Only the first element's block number sets the address
         if (el_b && eb_q == 2'd1 && elem_q == 8'h00) a2_q <= b;
         if (el_b && eb_q == 2'd0) e3_q <= ~b[7];
         if (rf_rx_in.last) begin
            eb_q   <= 2'd0;
            elem_q <= 8'h00;
         end else if (el_b) begin
            eb_q   <= e_end ? 2'd0 : eb_q + 2'd1;
            elem_q <= elem_nx;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event synchronisers from the link domain
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         f_sy_q  <= 3'b000;
         ok_sy_q <= 3'b000;
         er_sy_q <= 3'b000;
      end else begin
         f_sy_q  <= {f_sy_q[1:0], f_tgl_q};
         ok_sy_q <= {ok_sy_q[1:0], ok_tgl_q};
         er_sy_q <= {er_sy_q[1:0], er_tgl_q};
      end
   end

   wire logic f_ev    = f_sy_q[2] ^ f_sy_q[1];
   wire logic ok_ev   = ok_sy_q[2] ^ ok_sy_q[1];
   wire logic er_ev   = er_sy_q[2] ^ er_sy_q[1];
   wire logic tx_free = !tx_q.valid || rf_tx_ready_in;
   wire logic ld_data = (state_q == S_SEND) && tx_free;
   wire logic ld_err  = (state_q == S_ERROR) && tx_free;
   wire logic last_b  = (idx_q == fetch_q.len - 8'h01);
   wire logic f_tmo   = tmr_q >= FETCH_WAIT_CYC - 1;
   wire logic a_tmo   = tmr_q >= ANS_WAIT_CYC - 1;

   // ----------------------------------------------------------------
   // Relay sequence
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= S_IDLE;
         fetch_q <= '0;
         pend_q  <= 1'b0;
         irq_n_q <= 1'b1;
         tmr_q   <= 32'h0;
         idx_q   <= 8'h00;
      end else begin
         tmr_q <= tmr_q + 32'h1;
         case (state_q)
            S_IDLE: begin
               if (take && rf_rx_in.last) state_q <= S_CHECK;
            end
            S_CHECK: begin
               tmr_q <= 32'h0;
               if (ok_q) begin
                  fetch_q <= '{addr: addr_w, len: len_w};
                  pend_q  <= 1'b1;
                  irq_n_q <= 1'b0;                                 // RL18
                  state_q <= S_FETCH;
               end else begin
                  state_q <= S_ERROR;                              // RL7 RL9 RL10
               end
            end
            S_FETCH: begin
               if (f_ev) begin
                  irq_n_q <= 1'b1;
                  tmr_q   <= 32'h0;                                // RL20
                  state_q <= S_ANSWER;
               end else if (f_tmo) begin
                  irq_n_q <= 1'b1;                                 // RL19
                  pend_q  <= 1'b0;
                  state_q <= S_ERROR;
               end
            end
            S_ANSWER: begin
               if (ok_ev) begin
                  pend_q  <= 1'b0;
                  idx_q   <= 8'h00;
                  state_q <= S_SEND;                               // RL22
               end else if (er_ev || a_tmo) begin
                  pend_q  <= 1'b0;                                 // RL20
                  state_q <= S_ERROR;
               end
            end
            S_SEND: begin
               if (tx_free) begin
                  idx_q <= idx_q + 8'h01;
                  if (last_b) state_q <= S_IDLE;
               end
            end
            S_ERROR: begin
               if (tx_free) state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Response stream to the RF framer
   // ----------------------------------------------------------------
   // The answer buffer is static here: the link writes it only while a
   // fetch is pending, and pending has already dropped before sending
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_q <= '0;
      end else if (ld_data) begin
         tx_q <= '{valid: 1'b1, last: last_b, err: 1'b0, data: ans_buf[idx_q]}; // RL22
      end else if (ld_err) begin
         tx_q <= '{valid: 1'b1, last: 1'b1, err: 1'b1, data: 8'h00};
      end else if (rf_tx_ready_in) begin
         tx_q.valid <= 1'b0;
      end
   end

   assign rf_tx_out      = tx_q;
   assign host_irq_n_out = irq_n_q;

   // ----------------------------------------------------------------
   // Link domain: host command server
   // ----------------------------------------------------------------
   wire logic       pend_l  = pend_sy_q[1];
   wire logic       is_ans  = (cmd_q == ANS_NORMAL) || (cmd_q == ANS_ERROR);  // RL4
   wire logic       len_ok  = (cmd_q == ANS_NORMAL) ? (rxn_q == fetch_q.len)  // RL15
                                                    : (rxn_q == 8'h00);       // RL5
   wire logic       ans_ok  = pend_l && qseen_q && !adone_q && len_ok;
   wire logic       fet_ok  = pend_l && (rxn_q == 8'h00);                     // RL17
   wire logic       wr_buf  = host_rx_in.valid && !host_rx_in.first && cmd_q == ANS_NORMAL
                              && qseen_q && !adone_q && rxn_q < fetch_q.len;
   wire logic [7:0] fet_b   = (txi_q == 2'd0) ? (fet_ok ? STAT_OK : STAT_ERR) // RL13
                            : (txi_q == 2'd1) ? fetch_q.addr[15:8]            // RL13
                            : (txi_q == 2'd2) ? fetch_q.addr[7:0]
                            : fetch_q.len;                                    // RL14
   wire logic [7:0] rep_b   = (cmd_q == CMD_FETCH) ? fet_b                    // RL3
                            : (is_ans && txi_q == 2'd0 && ans_ok) ? STAT_OK   // RL16
                            : STAT_ERR;
   wire logic       fet_end = host_tx_req_in && cmd_q == CMD_FETCH && txi_q == 2'd3
                              && fet_ok && !qseen_q;
   wire logic       ans_end = host_tx_req_in && is_ans && txi_q == 2'd0 && ans_ok;

   always_ff @(posedge host_clk_in) begin
      if (wr_buf) ans_buf[rxn_q] <= host_rx_in.data;                           // RL15
   end

   always_ff @(posedge host_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pend_sy_q <= 2'b00;
         cmd_q     <= 8'h00;
         rxn_q     <= 8'h00;
         txi_q     <= 2'd0;
         qseen_q   <= 1'b0;
         adone_q   <= 1'b0;
         f_tgl_q   <= 1'b0;
         ok_tgl_q  <= 1'b0;
         er_tgl_q  <= 1'b0;
         htx_q     <= 8'h00;
      end else begin
         pend_sy_q <= {pend_sy_q[0], pend_q};
         if (host_rx_in.valid && host_rx_in.first) begin
            cmd_q <= host_rx_in.data;
            rxn_q <= 8'h00;
            txi_q <= 2'd0;
         end else if (host_rx_in.valid && rxn_q != 8'hff) begin
            rxn_q <= rxn_q + 8'h01;
         end
         if (host_tx_req_in) begin
            htx_q <= rep_b;
            if (txi_q != 2'd3) txi_q <= txi_q + 2'd1;
         end
         // Only the first normal fetch reply starts the answer wait
         if (fet_end) begin
            qseen_q <= 1'b1;
            f_tgl_q <= ~f_tgl_q;                                               // RL20
         end
         // The event leaves only once the status byte has gone out
         if (ans_end) begin
            adone_q <= 1'b1;
            if (cmd_q == ANS_NORMAL) ok_tgl_q <= ~ok_tgl_q;                    // RL22
            else er_tgl_q <= ~er_tgl_q;
         end
         if (!pend_l) begin
            qseen_q <= 1'b0;
            adone_q <= 1'b0;
         end
      end
   end

   assign host_tx_byte_out = htx_q;

endmodule // trr_read_relay
